// ---- rtcw_pkg.sv ----
package rtcw_pkg;
  // slave address decode
  localparam logic [3:0] ID_ARRAY = 4'hA;
  localparam logic [3:0] ID_CCR = 4'hD;
  localparam logic [2:0] DEV_SELECT = 3'h7;
  // control/clock area layout
  localparam logic [15:0] STATUS_ADDR = 16'h003F;
  localparam logic [15:0] CCR_LIMIT = 16'h003F;
  // status register command values
  localparam logic [7:0] SR_SET_WEL = 8'h02;
  localparam logic [7:0] SR_SET_REGISTER_WRITE_ENABLE_LATCH = 8'h06;
  localparam logic [7:0] SR_CLEAR = 8'h00;
  // page geometry
  localparam logic [5:0] ARRAY_PAGE_MASK = 6'h3F;
  localparam logic [5:0] CCR_PAGE_MASK = 6'h07;
  localparam logic [6:0] ARRAY_PAGE_BYTES = 7'h40;
  localparam logic [6:0] CCR_PAGE_BYTES = 7'h08;
  // block protect ranges, indexed by the protect code
  localparam logic [10:0] BP_LO [8] = '{11'h000, 11'h600, 11'h400, 11'h000,
                                        11'h000, 11'h000, 11'h000, 11'h000};
  localparam logic [10:0] BP_HI [8] = '{11'h000, 11'h7FF, 11'h7FF, 11'h7FF,
                                        11'h03F, 11'h07F, 11'h0FF, 11'h1FF};
  // timing
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned NV_WRITE_TIME_MS = 10;
  localparam int unsigned NV_WRITE_CYC = SYS_CLK_HZ / 1000 * NV_WRITE_TIME_MS;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned IRQ_PULSE_OSC_CYC = 1024;
  localparam longint unsigned IRQ_PULSE_CYC_L =
    longint'(IRQ_PULSE_OSC_CYC) * longint'(SYS_CLK_HZ) / longint'(OSC_HZ);
  localparam int unsigned IRQ_PULSE_CYC = int'(IRQ_PULSE_CYC_L);
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_NVCOUNT = 8'h08;
  // control fields
  localparam int CT_IM = 0;
  localparam int CT_ALARM0_IRQ_ENABLE = 1;
  localparam int CT_ALARM1_IRQ_ENABLE = 2;
  localparam int CT_BP_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // status fields
  localparam int ST_WEL = 0;
  localparam int ST_REGISTER_WRITE_ENABLE_LATCH = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_AL0 = 5;
  localparam int ST_AL1 = 6;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // serial byte phase
  typedef enum logic [1:0] {PH_IDLE, PH_RX, PH_ACK, PH_TX} rtcw_phase_e;
endpackage

// ---- rtcw_serial_slave.sv ----
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module rtcw_serial_slave #(
  parameter int unsigned NV_WRITE_CYC = rtcw_pkg::NV_WRITE_CYC,
  parameter int unsigned IRQ_PULSE_CYC = rtcw_pkg::IRQ_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic irq_n,
  input wire logic alarm0_match,
  input wire logic alarm1_match,
  output logic nv_wr_valid,
  output logic nv_wr_ccr,
  output logic [15:0] nv_wr_addr,
  output logic [7:0] nv_wr_data,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // the stream of a full page must fit inside the busy period
  if (NV_WRITE_CYC < 65) begin : g_bad_nv
    $error("nv write cycle too short for a page");
  end
  if (IRQ_PULSE_CYC < 1) begin : g_bad_pulse
    $error("irq pulse must last at least one cycle");
  end

  logic [1:0] scl_sync_q; // [0] is the metastable stage
  logic [1:0] sda_sync_q;
  logic scl_q; // previous synchronised levels
  logic sda_q;
  logic scl_s;
  logic sda_s;
  rtcw_pkg::rtcw_phase_e phase_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [1:0] byte_idx_q; // 0 slave, 1 addr high, 2 addr low, 3 data
  logic is_ccr_q;
  logic is_read_q;
  logic sess_q; // addressed write in progress
  logic [15:0] addr_q;
  logic [5:0] off_q;
  logic [5:0] start_off_q;
  logic [6:0] data_cnt_q;
  logic [7:0] first_byte_q;
  logic ack_q;
  logic ack_half_q;
  logic sda_drive_q;
  logic wel_q;
  logic register_write_enable_latch_q;
  logic busy_q;
  logic [31:0] busy_cnt_q;
  logic [6:0] si_q;
  logic [6:0] nv_len_q;
  logic nv_ccr_q;
  logic [15:0] nv_base_q;
  logic [5:0] nv_soff_q;
  logic [5:0] nv_mask_q;
  logic nv_wr_valid_q;
  logic [15:0] nv_wr_addr_q;
  logic [7:0] nv_wr_data_q;
  logic [31:0] nv_count_q;
  logic [7:0] buf_q [64]; // page load buffer
  logic [7:0] ctrl_q;
  logic alarm0_flag_q;
  logic alarm1_flag_q;
  logic [31:0] pulse_cnt_q;
  logic irq_n_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // input synchronisers and edge history
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];

  // bus events; all of them are deaf while the nv cycle runs
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  assign start_ev = !busy_q && scl_s && scl_q && sda_q && !sda_s;
  assign stop_ev = !busy_q && scl_s && scl_q && !sda_q && sda_s;
  assign scl_rise = !busy_q && !start_ev && !stop_ev && scl_s && !scl_q;
  assign scl_fall = !busy_q && !scl_s && scl_q;

  // decode helpers for the byte being completed
  logic [7:0] rx_byte;
  logic byte_done;
  logic id_ok;
  logic to_status;
  logic data_ack;
  logic [5:0] page_mask;
  logic [6:0] page_bytes;
  logic commit_ok;
  logic prot;
  logic nv_start;
  logic sr_commit;
  logic nv_last;
  logic [5:0] slot;
  logic [15:0] wa;
  assign rx_byte = {shift_q[6:0], sda_s};
  assign byte_done = phase_q == rtcw_pkg::PH_RX && scl_rise && bitcnt_q == 4'h7;
  assign id_ok = rx_byte[3:1] == rtcw_pkg::DEV_SELECT &&
    (rx_byte[7:4] == rtcw_pkg::ID_ARRAY || rx_byte[7:4] == rtcw_pkg::ID_CCR);
  assign to_status = is_ccr_q && addr_q == rtcw_pkg::STATUS_ADDR;
  // status takes exactly one byte; control needs both latches
  assign data_ack = to_status ? (data_cnt_q == 7'h00) :
    (wel_q && (!is_ccr_q || register_write_enable_latch_q));
  assign page_mask = is_ccr_q ? rtcw_pkg::CCR_PAGE_MASK : rtcw_pkg::ARRAY_PAGE_MASK;
  assign page_bytes = is_ccr_q ? rtcw_pkg::CCR_PAGE_BYTES : rtcw_pkg::ARRAY_PAGE_BYTES;
  // a stop only commits at a byte boundary after at least one acked byte;
  // it lands in the high half of the next byte's first clock, which was sampled
  assign commit_ok = stop_ev && sess_q && data_cnt_q != 7'h00 &&
    ((phase_q == rtcw_pkg::PH_RX && bitcnt_q <= 4'h1) ||
     phase_q == rtcw_pkg::PH_IDLE);
  assign prot = ctrl_q[rtcw_pkg::CT_BP_LSB +: 3] != 3'h0 &&
    addr_q[10:0] >= rtcw_pkg::BP_LO[ctrl_q[rtcw_pkg::CT_BP_LSB +: 3]] &&
    addr_q[10:0] <= rtcw_pkg::BP_HI[ctrl_q[rtcw_pkg::CT_BP_LSB +: 3]];
  assign nv_start = commit_ok && !to_status && (is_ccr_q || !prot);
  assign sr_commit = commit_ok && to_status;
  assign nv_last = busy_q && busy_cnt_q == 32'(NV_WRITE_CYC - 1);
  assign slot = 6'(nv_soff_q + si_q[5:0]) & nv_mask_q;
  assign wa = nv_base_q | {10'h000, slot};

  // serial byte engine: receive, acknowledge, transmit
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_q <= rtcw_pkg::PH_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      byte_idx_q <= 2'h0;
      is_ccr_q <= 1'b0;
      is_read_q <= 1'b0;
      sess_q <= 1'b0;
      addr_q <= 16'h0000;
      off_q <= 6'h00;
      start_off_q <= 6'h00;
      data_cnt_q <= 7'h00;
      first_byte_q <= 8'h00;
      ack_q <= 1'b0;
      ack_half_q <= 1'b0;
      sda_drive_q <= 1'b0;
    end
    else if (busy_q)
    begin
      // inputs disabled, line released until the nv cycle ends
      phase_q <= rtcw_pkg::PH_IDLE;
      sess_q <= 1'b0;
      sda_drive_q <= 1'b0;
    end
    else if (start_ev)
    begin
      // a start mid-write abandons the load; latches are left alone
      phase_q <= rtcw_pkg::PH_RX;
      bitcnt_q <= 4'h0;
      byte_idx_q <= 2'h0;
      sess_q <= 1'b0;
      data_cnt_q <= 7'h00;
      sda_drive_q <= 1'b0;
    end
    else if (stop_ev)
    begin
      phase_q <= rtcw_pkg::PH_IDLE;
      sess_q <= 1'b0;
      sda_drive_q <= 1'b0;
    end
    else
    begin
      case (phase_q)
        rtcw_pkg::PH_RX:
        begin
          if (scl_rise)
          begin
            shift_q <= rx_byte;
            bitcnt_q <= 4'(bitcnt_q + 4'h1);
            if (bitcnt_q == 4'h7)
            begin
              phase_q <= rtcw_pkg::PH_ACK;
              ack_half_q <= 1'b0;
              bitcnt_q <= 4'h0;
              if (byte_idx_q != 2'h3)
              begin
                byte_idx_q <= 2'(byte_idx_q + 2'h1);
              end
              case (byte_idx_q)
                2'h0:
                begin
                  ack_q <= id_ok;
                  is_ccr_q <= rx_byte[7:4] == rtcw_pkg::ID_CCR;
                  is_read_q <= rx_byte[0];
                  sess_q <= id_ok && !rx_byte[0];
                end
                2'h1:
                begin
                  ack_q <= 1'b1;
                  addr_q[15:8] <= rx_byte;
                end
                2'h2:
                begin
                  ack_q <= 1'b1;
                  addr_q[7:0] <= rx_byte;
                  off_q <= rx_byte[5:0] & page_mask;
                  start_off_q <= rx_byte[5:0] & page_mask;
                end
                default:
                begin
                  ack_q <= data_ack;
                  if (data_ack)
                  begin
                    // advance and wrap inside the page
                    off_q <= 6'(off_q + 6'h01) & page_mask;
                    if (data_cnt_q == 7'h00)
                    begin
                      first_byte_q <= rx_byte;
                    end
                    // past a page the count saturates: older bytes are overwritten
                    if (data_cnt_q != page_bytes)
                    begin
                      data_cnt_q <= 7'(data_cnt_q + 7'h01);
                    end
                  end
                end
              endcase
            end
          end
        end
        rtcw_pkg::PH_ACK:
        begin
          if (scl_fall)
          begin
            if (!ack_half_q)
            begin
              // drive low across the ninth clock
              sda_drive_q <= ack_q;
              ack_half_q <= 1'b1;
              if (!ack_q)
              begin
                phase_q <= rtcw_pkg::PH_IDLE;
              end
            end
            else
            begin
              sda_drive_q <= 1'b0;
              bitcnt_q <= 4'h0;
              phase_q <= is_read_q ? rtcw_pkg::PH_TX : rtcw_pkg::PH_RX;
            end
          end
        end
        rtcw_pkg::PH_TX:
        begin
          // read data lies outside this block: line stays released,
          // and the latch state is never touched here
          if (scl_rise)
          begin
            if (bitcnt_q == 4'h8)
            begin
              bitcnt_q <= 4'h0;
              if (sda_s)
              begin
                phase_q <= rtcw_pkg::PH_IDLE;
              end
            end
            else
            begin
              bitcnt_q <= 4'(bitcnt_q + 4'h1);
            end
          end
        end
        default:
        begin
          phase_q <= rtcw_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // page buffer; no reset, contents only matter once loaded
  always_ff @(posedge sys_clk)
  begin
    if (byte_done && byte_idx_q == 2'h3 && data_ack)
    begin
      buf_q[off_q] <= rx_byte;
    end
  end

  // write enable latches
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wel_q <= 1'b0;
      register_write_enable_latch_q <= 1'b0;
    end
    else if (sr_commit)
    begin
      case (first_byte_q)
        rtcw_pkg::SR_SET_WEL: wel_q <= 1'b1;
        rtcw_pkg::SR_SET_REGISTER_WRITE_ENABLE_LATCH:
        begin
          // the register latch only arms once the plain latch is set
          wel_q <= 1'b1;
          register_write_enable_latch_q <= register_write_enable_latch_q | wel_q;
        end
        rtcw_pkg::SR_CLEAR:
        begin
          wel_q <= 1'b0;
          register_write_enable_latch_q <= 1'b0;
        end
        default: ;
      endcase
    end
    else if (nv_last && nv_ccr_q)
    begin
      register_write_enable_latch_q <= 1'b0;
    end
  end

  // nv write cycle: stream the page out, then hold busy to the full time
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= 32'h0000_0000;
      si_q <= 7'h00;
      nv_len_q <= 7'h00;
      nv_ccr_q <= 1'b0;
      nv_base_q <= 16'h0000;
      nv_soff_q <= 6'h00;
      nv_mask_q <= 6'h00;
      nv_wr_valid_q <= 1'b0;
      nv_wr_addr_q <= 16'h0000;
      nv_wr_data_q <= 8'h00;
      nv_count_q <= 32'h0000_0000;
    end
    else if (nv_start)
    begin
      busy_q <= 1'b1;
      busy_cnt_q <= 32'h0000_0000;
      si_q <= 7'h00;
      nv_len_q <= data_cnt_q;
      nv_ccr_q <= is_ccr_q;
      nv_base_q <= addr_q & ~{10'h000, page_mask};
      nv_soff_q <= start_off_q;
      nv_mask_q <= page_mask;
    end
    else if (busy_q)
    begin
      busy_cnt_q <= 32'(busy_cnt_q + 32'h1);
      nv_wr_valid_q <= 1'b0;
      if (si_q != nv_len_q)
      begin
        si_q <= 7'(si_q + 7'h01);
        // bytes to undefined control locations are dropped
        nv_wr_valid_q <= !nv_ccr_q || wa < rtcw_pkg::CCR_LIMIT;
        nv_wr_addr_q <= wa;
        nv_wr_data_q <= buf_q[slot];
      end
      if (nv_last)
      begin
        busy_q <= 1'b0;
        nv_count_q <= 32'(nv_count_q + 32'h1);
      end
    end
  end

  // alarm flags and interrupt pin; a match wins over a clear
  logic clr_al0;
  logic clr_al1;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm0_flag_q <= 1'b0;
      alarm1_flag_q <= 1'b0;
      pulse_cnt_q <= 32'h0000_0000;
      irq_n_q <= 1'b1;
    end
    else
    begin
      // alarm0 flag is unused in pulsed mode
      alarm0_flag_q <= (alarm0_match && !ctrl_q[rtcw_pkg::CT_IM]) ||
        (alarm0_flag_q && !clr_al0);
      alarm1_flag_q <= alarm1_match || (alarm1_flag_q && !clr_al1);
      if (ctrl_q[rtcw_pkg::CT_IM] && alarm0_match)
      begin
        pulse_cnt_q <= 32'(IRQ_PULSE_CYC - 1);
      end
      else if (pulse_cnt_q != 32'h0000_0000)
      begin
        pulse_cnt_q <= 32'(pulse_cnt_q - 32'h1);
      end
      if (ctrl_q[rtcw_pkg::CT_IM])
      begin
        // enables are ignored; a retrigger restarts the pulse
        irq_n_q <= !(alarm0_match || pulse_cnt_q != 32'h0000_0000);
      end
      else
      begin
        irq_n_q <= !((alarm0_flag_q && ctrl_q[rtcw_pkg::CT_ALARM0_IRQ_ENABLE]) ||
          (alarm1_flag_q && ctrl_q[rtcw_pkg::CT_ALARM1_IRQ_ENABLE]));
      end
    end
  end

  // axi4-lite write channel: address and data in any order
  logic wr_go;
  logic wr_ctrl;
  logic wr_status;
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ctrl = wr_go && {awaddr_q[7:2], 2'h0} == rtcw_pkg::REG_CTRL;
  assign wr_status = wr_go && {awaddr_q[7:2], 2'h0} == rtcw_pkg::REG_STATUS;
  assign clr_al0 = wr_status && wstrb_q[0] && wdata_q[rtcw_pkg::ST_AL0];
  assign clr_al1 = wr_status && wstrb_q[0] && wdata_q[rtcw_pkg::ST_AL1];
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= rtcw_pkg::RESP_OKAY;
      ctrl_q <= rtcw_pkg::CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_ctrl || wr_status) ? rtcw_pkg::RESP_OKAY : rtcw_pkg::RESP_SLVERR;
        if (wr_ctrl && wstrb_q[0])
        begin
          ctrl_q <= wdata_q[7:0];
        end
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= rtcw_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rtcw_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'h0})
        rtcw_pkg::REG_CTRL: rdata_q <= {24'h000000, ctrl_q};
        rtcw_pkg::REG_STATUS:
        begin
          rdata_q[rtcw_pkg::ST_WEL] <= wel_q;
          rdata_q[rtcw_pkg::ST_REGISTER_WRITE_ENABLE_LATCH] <= register_write_enable_latch_q;
          rdata_q[rtcw_pkg::ST_BUSY] <= busy_q;
          rdata_q[rtcw_pkg::ST_AL0] <= alarm0_flag_q;
          rdata_q[rtcw_pkg::ST_AL1] <= alarm1_flag_q;
        end
        rtcw_pkg::REG_NVCOUNT: rdata_q <= nv_count_q;
        default: rresp_q <= rtcw_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n = !sda_drive_q;
  assign irq_n = irq_n_q;
  assign nv_wr_valid = nv_wr_valid_q;
  assign nv_wr_ccr = nv_ccr_q;
  assign nv_wr_addr = nv_wr_addr_q;
  assign nv_wr_data = nv_wr_data_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule // rtcw_serial_slave

// ---- rtcw_i2c_master.sv ----
`timescale 1ns/1ps
// bus master model; scl rests high between frames, sda released means pulled up
module rtcw_i2c_master (
  input wire logic sys_clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_m
);
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // one quarter of the 800 ns serial period per step
  task automatic sp(input logic c, input logic v);
    scl <= c;
    sda_m <= v;
    repeat (2) @(posedge sys_clk);
  endtask
  // data falls while clock high
  task automatic start;
    sp(scl, 1'b1);
    sp(1'b1, 1'b1);
    sp(1'b1, 1'b0);
    sp(1'b0, 1'b0);
  endtask
  // data rises while clock high
  task automatic stop;
    sp(1'b0, 1'b0);
    sp(1'b1, 1'b0);
    sp(1'b1, 1'b1);
  endtask
  // data only moves in the low half of the clock
  task automatic bit1(input logic v, output logic s);
    sp(1'b0, v);
    sp(1'b1, v);
    s = sda_w;
    sp(1'b1, v);
    sp(1'b0, v);
  endtask
  // n bits msb first; a full byte adds a released ninth clock
  task automatic send(input logic [7:0] b, input int n, output logic a);
    logic s;
    a = 1'b0;
    for (int i = 0; i < n; i++) bit1(b[7-i], s);
    if (n == 8) bit1(1'b1, s);
    if (n == 8) a = !s;
  endtask
endmodule // rtcw_i2c_master

// ---- rtcw_serial_slave_sva.sv ----
`timescale 1ns/1ps
// watches serial acks, the write stream and read answers
module rtcw_serial_slave_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_oe_n,
  input wire logic nv_wr_valid,
  input wire logic nv_wr_ccr,
  input wire logic [15:0] nv_wr_addr,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sda_edge_a: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data line moved while clock high");
  ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*7])
    else $error("acknowledge too short");
  page_wrap_a: assert property (nv_wr_valid && $past(nv_wr_valid) && !nv_wr_ccr |->
    nv_wr_addr == {$past(nv_wr_addr[15:6]), $past(nv_wr_addr[5:0]) + 6'h01})
    else $error("array stream address wrong");
  ccr_wrap_a: assert property (nv_wr_valid && $past(nv_wr_valid) && nv_wr_ccr |->
    nv_wr_addr == {$past(nv_wr_addr[15:3]), $past(nv_wr_addr[2:0]) + 3'h1})
    else $error("control stream address wrong");
  target_held_a: assert property (nv_wr_valid && $past(nv_wr_valid) |-> $stable(nv_wr_ccr))
    else $error("stream target changed");
  stream_quiet_a: assert property (nv_wr_valid |-> sda_oe_n)
    else $error("data line driven during write");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0B |=>
    s_axi_rresp == rtcw_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // rtcw_serial_slave_sva
bind rtcw_serial_slave rtcw_serial_slave_sva u_sva (.*);

// ---- rtcw_serial_slave_bench.sv ----
`timescale 1ns/1ps
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module rtcw_serial_slave_bench;
  logic sys_clk, rst, alarm0_match, alarm1_match, scl_i, sda_i, sda_m;
  logic sda_o, sda_oe_n, irq_n, nv_wr_valid, nv_wr_ccr;
  logic [15:0] nv_wr_addr, pa;
  logic [7:0] nv_wr_data, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures, checks_done, off, n;
  logic [7:0] dq [0:65];
  logic [7:0] ex [0:63];
  logic aq [$];
  logic [24:0] nvq [$];
  // short busy and pulse counts keep the run brief
  rtcw_serial_slave #(.NV_WRITE_CYC(200), .IRQ_PULSE_CYC(20)) u_dut (.*);
  rtcw_i2c_master u_mst (.sys_clk(sys_clk), .sda_w(sda_i), .scl(scl_i), .sda_m(sda_m));
  // wired-and line with pull-up
  assign sda_i = sda_m & (sda_oe_n | sda_o);
  always #50 sys_clk = ~sys_clk;
  // log every byte handed to the nonvolatile store
  always @(posedge sys_clk) if (nv_wr_valid) nvq.push_back({nv_wr_ccr, nv_wr_addr, nv_wr_data});
  // address k steps on, wrapping inside the page mask
  function automatic logic [15:0] wrap(input logic [15:0] a, input int k, input logic [15:0] m);
    return (a & ~m) | ((a + 16'(k)) & m);
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) rs = s_axi_bresp;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) v = s_axi_rdata;
      if (s_axi_rvalid) rs = s_axi_rresp;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_arvalid || s_axi_rready);
  endtask
  task automatic st;
    axr(rtcw_pkg::REG_STATUS, d, r);
  endtask
  // one frame: slave byte, address on writes, nd bytes, last one cut to bits
  task automatic fr(input logic [7:0] sl, input logic [15:0] ad, input int nd, input int bits,
                    input logic rs);
    logic a;
    aq.delete();
    u_mst.start();
    u_mst.send(sl, 8, a);
    aq.push_back(a);
    if (!sl[0]) u_mst.send(ad[15:8], 8, a);
    if (!sl[0]) aq.push_back(a);
    if (!sl[0]) u_mst.send(ad[7:0], 8, a);
    if (!sl[0]) aq.push_back(a);
    for (int i = 0; i < nd; i++)
    begin
      u_mst.send(sl[0] ? 8'hFF : dq[i], (i == nd - 1) ? bits : 8, a);
      aq.push_back(a);
    end
    if (rs) u_mst.start();
    u_mst.stop();
  endtask
  task automatic sr(input logic [7:0] v);
    dq[0] = v;
    fr(8'hDE, rtcw_pkg::STATUS_ADDR, 1, 8, 1'b0);
  endtask
  task automatic close_out;
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #5_000_000;
    failures++;
    close_out();
  end
  initial
  begin
    {sys_clk, alarm0_match, alarm1_match, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    rst = 1'b1;
    void'($urandom(32'hF287));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    st();
    `CK(d, 32'h0)
    axr(8'h0C, d, r);
    `CK(r, rtcw_pkg::RESP_SLVERR)
    axw(8'h0C, 32'h0, r);
    `CK(r, rtcw_pkg::RESP_SLVERR)
    fr(8'hBE, 16'h0, 0, 8, 1'b0);
    `CK(aq[0], 1'b0)
    dq[0] = 8'h5A;
    fr(8'hAE, 16'h0010, 1, 8, 1'b0);
    `CK({aq[0], aq[3]}, 2'b10)
    sr(8'h02);
    st();
    `CK(d[1:0], 2'b01)
    // page longer than 64 bytes from a random offset
    off = $urandom % 64;
    pa = 16'h00C0 | 16'(off);
    for (int i = 0; i < 66; i++)
    begin
      dq[i] = 8'($urandom);
      ex[(off + i) % 64] = dq[i];
    end
    fr(8'hAE, pa, 66, 8, 1'b0);
    n = 0;
    foreach (aq[i]) n += int'(aq[i]);
    `CK(n, 69)
    fr(8'hAE, 16'h0, 0, 8, 1'b0);
    `CK(aq[0], 1'b0)
    repeat (300) @(posedge sys_clk);
    `CK(nvq.size(), 64)
    for (int k = 0; k < 64; k++) `CK(nvq[k], {1'b0, wrap(pa, k, 16'h003F), ex[(off + k) % 64]})
    fr(8'hAE, 16'h0100, 1, 4, 1'b0);
    repeat (300) @(posedge sys_clk);
    `CK(nvq.size(), 64)
    sr(8'h02);
    fr(8'hAF, 16'h0, 1, 8, 1'b0);
    `CK({aq[0], aq[1]}, 2'b10)
    sr(8'h06);
    st();
    `CK(d[1:0], 2'b11)
    dq[0] = 8'($urandom);
    dq[1] = 8'($urandom);
    fr(8'hDE, 16'h0002, 1, 8, 1'b1);
    st();
    `CK(d[1:0], 2'b11)
    fr(8'hDE, 16'h0007, 2, 8, 1'b0);
    repeat (300) @(posedge sys_clk);
    `CK(nvq.size(), 66)
    `CK(nvq[65], {1'b1, 16'h0000, dq[1]})
    st();
    `CK(d[1:0], 2'b01)
    dq[0] = 8'h00;
    fr(8'hDE, rtcw_pkg::STATUS_ADDR, 2, 8, 1'b0);
    `CK(aq[4], 1'b0)
    st();
    `CK(d[1:0], 2'b00)
    // first page protected: acked, but no busy and nothing streamed
    axw(rtcw_pkg::REG_CTRL, 32'h0000_0040, r);
    sr(8'h02);
    dq[0] = 8'($urandom);
    fr(8'hAE, 16'h0010, 1, 8, 1'b0);
    `CK(aq[3], 1'b1)
    st();
    `CK(d[2:0], 3'b001)
    fr(8'hAE, 16'h0020, 0, 8, 1'b0);
    `CK(aq[0], 1'b1)
    `CK(nvq.size(), 66)
    // pulsed mode with both enables set
    axw(rtcw_pkg::REG_CTRL, 32'h0000_0007, r);
    @(posedge sys_clk) alarm0_match <= 1'b1;
    @(posedge sys_clk) alarm0_match <= 1'b0;
    n = 0;
    repeat (40) @(posedge sys_clk) n += int'(!irq_n);
    `CK(n, 20)
    @(posedge sys_clk) alarm1_match <= 1'b1;
    @(posedge sys_clk) alarm1_match <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CK(irq_n, 1'b1)
    st();
    `CK(d[6], 1'b1)
    close_out();
  end
endmodule // rtcw_serial_slave_bench
